// *** rtl/dsg_config.sv ***
/*
 * Register bank for clock-recovery loop gains and gain-control limits.
 * Assumes a same-clock register master and a sync-found level from the
 * demodulator on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dsg_config
  import dsg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // Demodulator status
  input wire logic sync_found,
  // Clock recovery settings
  output logic [GAIN_W-1:0] integral_gain,
  output logic [GAIN_W-1:0] proportional_gain,
  output logic rate_comp_enable,
  output logic [LIMIT_W-1:0] rate_offset_limit,
  // Gain control settings
  output logic [1:0] digital_gain_ceiling,
  output logic [BACKOFF_W-1:0] front_end_backoff,
  output logic [TARGET_W-1:0] amplitude_target_db
);
  typedef struct packed {
    logic [DATA_W-1:0] bsync;
    logic [DATA_W-1:0] limits;
    logic [DATA_W-1:0] rdata;
    logic [GAIN_W-1:0] ki;
    logic [GAIN_W-1:0] kp;
  } dsg_state_t;

  dsg_state_t s_q;
  dsg_state_t s_d;

  // Pre-sync code n gives (n+1) times base, in half-base units
  function automatic logic [GAIN_W-1:0] pre_gain(input logic [1:0] code);
    pre_gain = GAIN_W'({code, 1'b0}) + GAIN_ONE;
  endfunction : pre_gain

  function automatic logic [DATA_W-1:0] read_mux(
    input logic [ADDR_W-1:0] a, input dsg_state_t s);
    if (a == BIT_SYNC_CONFIG_ADDR) begin
      read_mux = s.bsync;
    end else if (a == GAIN_CONTROL_LIMITS_ADDR) begin
      read_mux = s.limits;
    end else begin
      read_mux = UNMAPPED_READ;
    end
  endfunction : read_mux

  logic [1:0] limit_code;

  always_comb begin
    s_d = s_q;
    if (reg_write && reg_addr == BIT_SYNC_CONFIG_ADDR) begin
      s_d.bsync = reg_wdata;
    end
    if (reg_write && reg_addr == GAIN_CONTROL_LIMITS_ADDR) begin
      s_d.limits = reg_wdata;
    end
    s_d.rdata = reg_read ? read_mux(reg_addr, s_q) : s_q.rdata;
    // Gains follow the written register the very next cycle
    if (!sync_found) begin
      s_d.ki = pre_gain(s_d.bsync[PRE_KI_LSB +: 2]);
      s_d.kp = pre_gain(s_d.bsync[PRE_KP_LSB +: 2]);
    end else begin
      s_d.ki = s_d.bsync[POST_KI_BIT] ? GAIN_HALF
        : pre_gain(s_d.bsync[PRE_KI_LSB +: 2]);
      s_d.kp = s_d.bsync[POST_KP_BIT] ? GAIN_ONE
        : pre_gain(s_d.bsync[PRE_KP_LSB +: 2]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.bsync <= BIT_SYNC_CONFIG_RESET;
      s_q.limits <= GAIN_CONTROL_LIMITS_RESET;
      s_q.rdata <= UNMAPPED_READ;
      s_q.ki <= GAIN_ONE + GAIN_ONE;
      s_q.kp <= GAIN_ONE + GAIN_ONE + GAIN_ONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign integral_gain = s_q.ki;
  assign proportional_gain = s_q.kp;
  assign limit_code = s_q.bsync[LIMIT_LSB +: 2];
  assign rate_comp_enable = (limit_code != 2'b00);

  always_comb begin
    unique case (limit_code)
      2'b00: rate_offset_limit = LIMIT_NONE;
      2'b01: rate_offset_limit = LIMIT_3P125;
      2'b10: rate_offset_limit = LIMIT_6P25;
      2'b11: rate_offset_limit = LIMIT_12P5;
    endcase
  end

  // Decode of ceilings and target
  dsg_gain_decode u_gain_decode (
    .limits(s_q.limits),
    .digital_gain_ceiling(digital_gain_ceiling),
    .front_end_backoff(front_end_backoff),
    .amplitude_target_db(amplitude_target_db)
  );

  // Register port behaviour
  AST_WRITE_READBACK: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_write && reg_addr == BIT_SYNC_CONFIG_ADDR ##1
    reg_read && reg_addr == BIT_SYNC_CONFIG_ADDR
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Bit sync readback mismatch");
  AST_LIMITS_READBACK: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_read && reg_addr == GAIN_CONTROL_LIMITS_ADDR
    |=> reg_rdata == $past(s_q.limits))
    else $error("Gain limits readback mismatch");
  AST_UNMAPPED_READ: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_read && reg_addr != BIT_SYNC_CONFIG_ADDR
    && reg_addr != GAIN_CONTROL_LIMITS_ADDR |=> reg_rdata == UNMAPPED_READ)
    else $error("Unmapped read not zero");
  AST_RDATA_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    !reg_read |=> $stable(reg_rdata))
    else $error("Read data changed without a read");
  // Loop gains after sync
  AST_POST_KI: assert property (
    @(posedge clk) disable iff (!reset_n)
    sync_found && s_d.bsync[POST_KI_BIT] |=> integral_gain == GAIN_HALF)
    else $error("Post-sync integral gain not half base");
  AST_POST_KI_SAME: assert property (
    @(posedge clk) disable iff (!reset_n)
    sync_found && !s_d.bsync[POST_KI_BIT]
    && s_d.bsync[PRE_KI_LSB +: 2] == 2'b00 |=> integral_gain == GAIN_ONE)
    else $error("Post-sync integral gain not pre-sync gain");
  AST_POST_KP: assert property (
    @(posedge clk) disable iff (!reset_n)
    sync_found && s_d.bsync[POST_KP_BIT] |=> proportional_gain == GAIN_ONE)
    else $error("Post-sync proportional gain not base");
  AST_POST_KP_SAME: assert property (
    @(posedge clk) disable iff (!reset_n)
    sync_found && !s_d.bsync[POST_KP_BIT]
    && s_d.bsync[PRE_KP_LSB +: 2] == 2'b11 |=> proportional_gain == 4'h8)
    else $error("Post-sync proportional gain not pre-sync gain");
  // Loop gains before sync, in half-base units
  AST_PRE_KI: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sync_found && s_d.bsync[PRE_KI_LSB +: 2] == 2'b11
    |=> integral_gain == 4'h8)
    else $error("Pre-sync integral gain not four times base");
  AST_PRE_KI_0: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sync_found && s_d.bsync[PRE_KI_LSB +: 2] == 2'b00
    |=> integral_gain == GAIN_ONE)
    else $error("Pre-sync integral gain not base");
  AST_PRE_KI_1: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sync_found && s_d.bsync[PRE_KI_LSB +: 2] == 2'b01
    |=> integral_gain == 4'h4)
    else $error("Pre-sync integral gain not twice base");
  AST_PRE_KI_2: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sync_found && s_d.bsync[PRE_KI_LSB +: 2] == 2'b10
    |=> integral_gain == 4'h6)
    else $error("Pre-sync integral gain not three times base");
  AST_PRE_KP_0: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sync_found && s_d.bsync[PRE_KP_LSB +: 2] == 2'b00
    |=> proportional_gain == GAIN_ONE)
    else $error("Pre-sync proportional gain not base");
  AST_PRE_KP_1: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sync_found && s_d.bsync[PRE_KP_LSB +: 2] == 2'b01
    |=> proportional_gain == 4'h4)
    else $error("Pre-sync proportional gain not twice base");
  AST_PRE_KP_2: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sync_found && s_d.bsync[PRE_KP_LSB +: 2] == 2'b10
    |=> proportional_gain == 4'h6)
    else $error("Pre-sync proportional gain not three times base");
  AST_PRE_KP_3: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sync_found && s_d.bsync[PRE_KP_LSB +: 2] == 2'b11
    |=> proportional_gain == 4'h8)
    else $error("Pre-sync proportional gain not four times base");
  // Rate offset compensation
  AST_NO_COMP: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.bsync[LIMIT_LSB +: 2] == 2'b00 |-> !rate_comp_enable
    && rate_offset_limit == LIMIT_NONE)
    else $error("Compensation active with zero limit");
  AST_COMP_ON: assert property (
    @(posedge clk) disable iff (!reset_n)
    limit_code != 2'b00 |-> rate_comp_enable)
    else $error("Compensation off with nonzero limit");
  AST_LIMIT_MAX: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_write && reg_addr == BIT_SYNC_CONFIG_ADDR
    && reg_wdata[LIMIT_LSB +: 2] == 2'b11 |=> rate_offset_limit == LIMIT_12P5)
    else $error("Limit code 3 not 12.5 percent");
  AST_LIMIT_LOW: assert property (
    @(posedge clk) disable iff (!reset_n)
    limit_code == 2'b01 |-> rate_offset_limit == LIMIT_3P125)
    else $error("Limit code 1 not 3.125 percent");
  AST_LIMIT_MID: assert property (
    @(posedge clk) disable iff (!reset_n)
    limit_code == 2'b10 |-> rate_offset_limit == LIMIT_6P25)
    else $error("Limit code 2 not 6.25 percent");
  // Gain control ceilings
  AST_DIG_CEIL: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_write && reg_addr == GAIN_CONTROL_LIMITS_ADDR
    |=> digital_gain_ceiling == $past(reg_wdata[DIG_CEIL_LSB +: 2]))
    else $error("Digital ceiling not updated");
  AST_FE_CEIL: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_write && reg_addr == GAIN_CONTROL_LIMITS_ADDR
    && reg_wdata[FE_CEIL_LSB +: 3] == 3'h4 |=> front_end_backoff == FE_BACKOFF_4)
    else $error("Front-end ceiling code 4 wrong");
  AST_FE_0: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[FE_CEIL_LSB +: 3] == 3'h0 |-> front_end_backoff == FE_BACKOFF_0)
    else $error("Front-end ceiling code 0 not full gain");
  AST_FE_1: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[FE_CEIL_LSB +: 3] == 3'h1 |-> front_end_backoff == FE_BACKOFF_1)
    else $error("Front-end ceiling code 1 wrong");
  AST_FE_2: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[FE_CEIL_LSB +: 3] == 3'h2 |-> front_end_backoff == FE_BACKOFF_2)
    else $error("Front-end ceiling code 2 wrong");
  AST_FE_3: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[FE_CEIL_LSB +: 3] == 3'h3 |-> front_end_backoff == FE_BACKOFF_3)
    else $error("Front-end ceiling code 3 wrong");
  AST_FE_5: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[FE_CEIL_LSB +: 3] == 3'h5 |-> front_end_backoff == FE_BACKOFF_5)
    else $error("Front-end ceiling code 5 wrong");
  AST_FE_6: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[FE_CEIL_LSB +: 3] == 3'h6 |-> front_end_backoff == FE_BACKOFF_6)
    else $error("Front-end ceiling code 6 wrong");
  AST_FE_7: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[FE_CEIL_LSB +: 3] == 3'h7 |-> front_end_backoff == FE_BACKOFF_7)
    else $error("Front-end ceiling code 7 wrong");
  // Amplitude target
  AST_TARGET: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_write && reg_addr == GAIN_CONTROL_LIMITS_ADDR
    && reg_wdata[AMP_TGT_LSB +: 3] == 3'h7 |=> amplitude_target_db == TGT_DB_7)
    else $error("Amplitude target code 7 wrong");
  AST_TGT_0: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[AMP_TGT_LSB +: 3] == 3'h0 |-> amplitude_target_db == TGT_DB_0)
    else $error("Amplitude target code 0 wrong");
  AST_TGT_1: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[AMP_TGT_LSB +: 3] == 3'h1 |-> amplitude_target_db == TGT_DB_1)
    else $error("Amplitude target code 1 wrong");
  AST_TGT_2: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[AMP_TGT_LSB +: 3] == 3'h2 |-> amplitude_target_db == TGT_DB_2)
    else $error("Amplitude target code 2 wrong");
  AST_TGT_3: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[AMP_TGT_LSB +: 3] == 3'h3 |-> amplitude_target_db == TGT_DB_3)
    else $error("Amplitude target code 3 wrong");
  AST_TGT_4: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[AMP_TGT_LSB +: 3] == 3'h4 |-> amplitude_target_db == TGT_DB_4)
    else $error("Amplitude target code 4 wrong");
  AST_TGT_5: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[AMP_TGT_LSB +: 3] == 3'h5 |-> amplitude_target_db == TGT_DB_5)
    else $error("Amplitude target code 5 wrong");
  AST_TGT_6: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_q.limits[AMP_TGT_LSB +: 3] == 3'h6 |-> amplitude_target_db == TGT_DB_6)
    else $error("Amplitude target code 6 wrong");
endmodule : dsg_config
`default_nettype wire

// *** include/dsg_pkg.sv ***
/*
 * Package for the demodulator sync and gain configuration bank.
 * Assumes a plain register port with 8-bit data, one register per address.
 */
package dsg_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] BIT_SYNC_CONFIG_ADDR = 6'h1a;
  localparam logic [5:0] GAIN_CONTROL_LIMITS_ADDR = 6'h1b;
  localparam logic [7:0] BIT_SYNC_CONFIG_RESET = 8'h6c;
  localparam logic [7:0] GAIN_CONTROL_LIMITS_RESET = 8'h03;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Bit sync config fields
  localparam int PRE_KI_LSB = 6;
  localparam int PRE_KP_LSB = 4;
  localparam int POST_KI_BIT = 3;
  localparam int POST_KP_BIT = 2;
  localparam int LIMIT_LSB = 0;
  // Gain control limit fields
  localparam int DIG_CEIL_LSB = 6;
  localparam int FE_CEIL_LSB = 3;
  localparam int AMP_TGT_LSB = 0;
  // Gains are given in half steps of the base gain: 2 means 1x base
  localparam int GAIN_W = 4;
  localparam logic [3:0] GAIN_HALF = 4'h1;
  localparam logic [3:0] GAIN_ONE = 4'h2;
  // Rate limit in units of 1/32 percent: 3.125 % = 100
  localparam int LIMIT_W = 9;
  localparam logic [8:0] LIMIT_NONE = 9'h000;
  localparam logic [8:0] LIMIT_3P125 = 9'h064;
  localparam logic [8:0] LIMIT_6P25 = 9'h0c8;
  localparam logic [8:0] LIMIT_12P5 = 9'h190;
  // Front-end backoff in tenths of a dB
  localparam int BACKOFF_W = 8;
  localparam logic [7:0] FE_BACKOFF_0 = 8'h00;
  localparam logic [7:0] FE_BACKOFF_1 = 8'h1a;
  localparam logic [7:0] FE_BACKOFF_2 = 8'h3d;
  localparam logic [7:0] FE_BACKOFF_3 = 8'h4a;
  localparam logic [7:0] FE_BACKOFF_4 = 8'h5c;
  localparam logic [7:0] FE_BACKOFF_5 = 8'h73;
  localparam logic [7:0] FE_BACKOFF_6 = 8'h92;
  localparam logic [7:0] FE_BACKOFF_7 = 8'hab;
  // Amplitude target in dB
  localparam int TARGET_W = 6;
  localparam logic [5:0] TGT_DB_0 = 6'h18;
  localparam logic [5:0] TGT_DB_1 = 6'h1b;
  localparam logic [5:0] TGT_DB_2 = 6'h1e;
  localparam logic [5:0] TGT_DB_3 = 6'h21;
  localparam logic [5:0] TGT_DB_4 = 6'h24;
  localparam logic [5:0] TGT_DB_5 = 6'h26;
  localparam logic [5:0] TGT_DB_6 = 6'h28;
  localparam logic [5:0] TGT_DB_7 = 6'h2a;
endpackage : dsg_pkg

// *** rtl/dsg_gain_decode.sv ***
/*
 * Decodes the gain-control limit register into datapath values.
 * Assumes the register value is a stable flop output on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dsg_gain_decode
  import dsg_pkg::*;
(
  // Register value
  input wire logic [DATA_W-1:0] limits,
  // Decoded settings
  output logic [1:0] digital_gain_ceiling,
  output logic [BACKOFF_W-1:0] front_end_backoff,
  output logic [TARGET_W-1:0] amplitude_target_db
);
  logic [2:0] fe_code;
  logic [2:0] tgt_code;

  assign fe_code = limits[FE_CEIL_LSB +: 3];
  assign tgt_code = limits[AMP_TGT_LSB +: 3];
  assign digital_gain_ceiling = limits[DIG_CEIL_LSB +: 2];

  always_comb begin
    unique case (fe_code)
      3'h0: front_end_backoff = FE_BACKOFF_0;
      3'h1: front_end_backoff = FE_BACKOFF_1;
      3'h2: front_end_backoff = FE_BACKOFF_2;
      3'h3: front_end_backoff = FE_BACKOFF_3;
      3'h4: front_end_backoff = FE_BACKOFF_4;
      3'h5: front_end_backoff = FE_BACKOFF_5;
      3'h6: front_end_backoff = FE_BACKOFF_6;
      3'h7: front_end_backoff = FE_BACKOFF_7;
    endcase
  end

  always_comb begin
    unique case (tgt_code)
      3'h0: amplitude_target_db = TGT_DB_0;
      3'h1: amplitude_target_db = TGT_DB_1;
      3'h2: amplitude_target_db = TGT_DB_2;
      3'h3: amplitude_target_db = TGT_DB_3;
      3'h4: amplitude_target_db = TGT_DB_4;
      3'h5: amplitude_target_db = TGT_DB_5;
      3'h6: amplitude_target_db = TGT_DB_6;
      3'h7: amplitude_target_db = TGT_DB_7;
    endcase
  end
endmodule : dsg_gain_decode
`default_nettype wire

// *** tb/dsg_config_tb.sv ***
/*
 * Self-checking bench for the sync and gain configuration bank.
 * Assumes dsg_pkg is compiled first; the bench drives every port itself.
 */
`timescale 1ns/1ps
`default_nettype none
module dsg_config_tb;
  import dsg_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic sync_found = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [GAIN_W-1:0] integral_gain;
  logic [GAIN_W-1:0] proportional_gain;
  logic rate_comp_enable;
  logic [LIMIT_W-1:0] rate_offset_limit;
  logic [1:0] digital_gain_ceiling;
  logic [BACKOFF_W-1:0] front_end_backoff;
  logic [TARGET_W-1:0] amplitude_target_db;
  int err_count = 0;
  int checked = 0;
  int seed_val;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [7:0] bsc = 8'h6c;
  logic [7:0] gcl = 8'h03;
  int lim_tab[4] = '{0, 100, 200, 400};
  int fe_tab[8] = '{0, 26, 61, 74, 92, 115, 146, 171};
  int tgt_tab[8] = '{24, 27, 30, 33, 36, 38, 40, 42};

  dsg_config dsg_config_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sync_found(sync_found),
    .integral_gain(integral_gain), .proportional_gain(proportional_gain),
    .rate_comp_enable(rate_comp_enable),
    .rate_offset_limit(rate_offset_limit),
    .digital_gain_ceiling(digital_gain_ceiling),
    .front_end_backoff(front_end_backoff),
    .amplitude_target_db(amplitude_target_db)
  );

  always #5 clk = ~clk;

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Read data is checked only in the cycle after the strobe; it holds until the next read
  always @(posedge clk) rd_pend <= reg_read;
  always @(negedge clk) begin
    if (rd_pend) begin
      chk("reg_rdata", exp_q.pop_front(), {8'h00, reg_rdata});
    end
  end

  task automatic op(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= wr;
    reg_read <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    if (!wr) begin
      exp_q.push_back(a == BIT_SYNC_CONFIG_ADDR ? bsc :
                      a == GAIN_CONTROL_LIMITS_ADDR ? gcl : 8'h00);
    end
    if (wr && a == BIT_SYNC_CONFIG_ADDR) bsc = d;
    if (wr && a == GAIN_CONTROL_LIMITS_ADDR) gcl = d;
  endtask : op

  // Two edges: one to drive sync_found, one for the registered gains
  task automatic settle(input logic s);
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    sync_found <= s;
    repeat (2) @(negedge clk);
  endtask : settle

  task automatic check_all();
    int ki;
    int kp;
    ki = (sync_found && bsc[3]) ? 1 : 2 * (bsc[7:6] + 1);
    kp = (sync_found && bsc[2]) ? 2 : 2 * (bsc[5:4] + 1);
    chk("integral_gain", ki, integral_gain);
    chk("proportional_gain", kp, proportional_gain);
    chk("rate_comp_enable", bsc[1:0] != 2'b00, rate_comp_enable);
    chk("rate_offset_limit", lim_tab[bsc[1:0]], rate_offset_limit);
    chk("digital_gain_ceiling", gcl[7:6], digital_gain_ceiling);
    chk("front_end_backoff", fe_tab[gcl[5:3]], front_end_backoff);
    chk("amplitude_target_db", tgt_tab[gcl[2:0]], amplitude_target_db);
  endtask : check_all

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    seed_val = $urandom(32'h1c93);
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check_all();
    op(1'b0, BIT_SYNC_CONFIG_ADDR, 8'h00);
    op(1'b0, GAIN_CONTROL_LIMITS_ADDR, 8'h00);
    settle(1'b1);
    check_all();
    $display("Test reset values done");
    // First eight passes sweep every code, the rest are random
    for (int i = 0; i < 24; i++) begin
      op(1'b1, GAIN_CONTROL_LIMITS_ADDR, (i < 8) ?
         {i[1:0], i[2:0], ~i[2:0]} : 8'($urandom));
      op(1'b1, BIT_SYNC_CONFIG_ADDR, (i < 8) ?
         {i[1:0], i[2:1], i[0], i[1], i[1:0]} : 8'($urandom));
      op(1'b0, BIT_SYNC_CONFIG_ADDR, 8'h00);
      op(1'b0, GAIN_CONTROL_LIMITS_ADDR, 8'h00);
      settle(1'b0);
      check_all();
      settle(1'b1);
      check_all();
    end
    $display("Test field sweep done");
    op(1'b1, 6'h1c, 8'hff);
    op(1'b1, 6'h00, 8'hff);
    op(1'b0, 6'h3f, 8'h00);
    op(1'b0, BIT_SYNC_CONFIG_ADDR, 8'h00);
    op(1'b0, GAIN_CONTROL_LIMITS_ADDR, 8'h00);
    settle(1'b0);
    check_all();
    $display("Test unmapped access done");
    @(posedge clk);
    reset_n <= 1'b0;
    bsc = 8'h6c;
    gcl = 8'h03;
    @(posedge clk);
    reset_n <= 1'b1;
    op(1'b0, BIT_SYNC_CONFIG_ADDR, 8'h00);
    op(1'b0, GAIN_CONTROL_LIMITS_ADDR, 8'h00);
    settle(1'b0);
    check_all();
    $display("Test second reset done");
    give_verdict();
  end
endmodule : dsg_config_tb
`default_nettype wire
